// ==== pkg/eprgc_defs.vh ====
`ifndef EPRGC_DEFS_VH
`define EPRGC_DEFS_VH
// ========================================
// Register map and fields
`define EPRGC_ADDR_W 16
`define EPRGC_REG_CTRL 16'h001E
`define EPRGC_REG_OPTION 16'h002F
`define EPRGC_REG_STATUS 16'h0030
`define EPRGC_BIT_LATCH 2
`define EPRGC_BIT_OPT_PWR 1
`define EPRGC_BIT_ARR_PWR 0
`define EPRGC_BIT_OSC_SEL 0
`define EPRGC_BIT_LOCK 7
`define EPRGC_STAT_BOOT 0
`define EPRGC_STAT_LOCK 1
`define EPRGC_STAT_CAPT 2
`define EPRGC_STAT_BYTE_MET 3
`define EPRGC_STAT_OPT_MET 4
`define EPRGC_STAT_COPY 5
`define EPRGC_STAT_VERIFY 6
`define EPRGC_ZERO8 8'h00
`define EPRGC_ERASED8 8'hFF
// ========================================
// Memory ranges
`define EPRGC_ARR_LO 16'h0600
`define EPRGC_ARR_HI 16'h1DFF
`define EPRGC_BOOT_LO 16'h1E00
`define EPRGC_BOOT_HI 16'h1FEF
`define EPRGC_VEC_LO 16'h1FF0
`define EPRGC_VEC_HI 16'h1FFF
// ========================================
// Timing
`define EPRGC_CLK_MHZ 40
`define EPRGC_BYTE_PROG_US 4
`define EPRGC_OPT_PROG_US 4
`define EPRGC_BOOT_PROG_US 1000
`define EPRGC_BYTE_PROG_CYC (`EPRGC_BYTE_PROG_US * `EPRGC_CLK_MHZ)
`define EPRGC_BOOT_PROG_CYC (`EPRGC_BOOT_PROG_US * `EPRGC_CLK_MHZ)
`define EPRGC_OPT_PROG_CYC (`EPRGC_OPT_PROG_US * `EPRGC_CLK_MHZ)
`define EPRGC_STRAP_WAIT 2'h2
`define EPRGC_STRAP_STEP 2'h1
`define EPRGC_CNT_W 16
`endif

// ==== core/eprgc_top.v ====
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "eprgc_defs.vh"
// Operation
// - Oscillator select held in option byte 0x2F
// - Lock set denies array access outside user
// - Lock bit write-only, read undefined
// - Osc select moves two port pins
// - Boot mode on reset release with straps
// - Boot program lives at 0x1E00-0x1FEF
// - Boot copies at 1 ms, then verifies
// - Control register at address 0x1E
// - Array spans 0x0600-0x1DFF plus 0x1FF0-0x1FFF
// - Control reads zero in normal operation
// - Array power set needs latch already set
// - Latch clear also clears array power
// - Option power routes voltage to option byte
// - Latch on: next array write captured, reads blocked
// - Setting latch and power together sets latch only
// - Erased array bit reads as one
module eprgc_top (
  input wire clock,
  input wire reset_n,
  input wire [15:0] wb_adr_i,
  input wire [7:0] wb_dat_i,
  output reg [7:0] wb_dat_o,
  input wire wb_we_i,
  input wire wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  input wire user_mode,
  input wire test_level_voltage,
  input wire boot_select_pin,
  input wire [7:0] array_rd_data,
  output reg array_prog_power,
  output reg option_prog_power,
  output reg prog_bus_latch,
  output reg [15:0] prog_addr,
  output reg [7:0] prog_data,
  output reg prog_captured,
  output reg [7:0] option_config_byte,
  output reg option_written,
  output reg ext_osc_select,
  output reg bootloader_mode,
  output reg bootloader_rom_sel
);

  // ========================================
  // Decoding
  function in_array;
    input [15:0] a;
    begin
      in_array = ((a >= `EPRGC_ARR_LO) && (a <= `EPRGC_ARR_HI)) ||
                 ((a >= `EPRGC_VEC_LO) && (a <= `EPRGC_VEC_HI));
    end
  endfunction

  function in_boot;
    input [15:0] a;
    begin
      in_boot = (a >= `EPRGC_BOOT_LO) && (a <= `EPRGC_BOOT_HI);
    end
  endfunction

  function [`EPRGC_CNT_W-1:0] prog_limit;
    input integer which;
    input boot;
    reg [31:0] full;
    begin
      full = `EPRGC_OPT_PROG_CYC;
      if (which == 0) begin
        full = boot ? `EPRGC_BOOT_PROG_CYC : `EPRGC_BYTE_PROG_CYC;
      end
      prog_limit = full[`EPRGC_CNT_W-1:0];
    end
  endfunction

  function [7:0] ctrl_view;
    input latch;
    input opt_pwr;
    input arr_pwr;
    begin
      ctrl_view = `EPRGC_ZERO8;
      ctrl_view[`EPRGC_BIT_LATCH] = latch;
      ctrl_view[`EPRGC_BIT_OPT_PWR] = opt_pwr;
      ctrl_view[`EPRGC_BIT_ARR_PWR] = arr_pwr;
    end
  endfunction

  function [7:0] stat_view;
    input boot;
    input lock;
    input captured;
    input [1:0] met;
    input [2:0] phase;
    begin
      stat_view = `EPRGC_ZERO8;
      stat_view[`EPRGC_STAT_BOOT] = boot;
      stat_view[`EPRGC_STAT_LOCK] = lock;
      stat_view[`EPRGC_STAT_CAPT] = captured;
      stat_view[`EPRGC_STAT_BYTE_MET] = met[0];
      stat_view[`EPRGC_STAT_OPT_MET] = met[1];
      stat_view[`EPRGC_STAT_COPY] = phase[1];
      stat_view[`EPRGC_STAT_VERIFY] = phase[2];
    end
  endfunction

  // ========================================
  // Pin synchronisers
  wire [2:0] pin_raw = {user_mode, boot_select_pin, test_level_voltage};
  wire [2:0] pin_sync;
  wire test_level_voltage_level = pin_sync[0];
  wire boot_level = pin_sync[1];
  wire user_level = pin_sync[2];
  genvar gi;

  // Each pin level passes two stages before use
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg [1:0] stage;
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          stage <= 2'h0;
        end else begin
          stage <= {stage[0], pin_raw[gi]};
        end
      end
      assign pin_sync[gi] = stage[1];
    end
  endgenerate

  // ========================================
  // Straps caught once the synchronisers hold the pin levels
  reg [1:0] strap_wait;
  reg strap_taken;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      bootloader_mode <= 1'b0;
    end else if (!strap_taken) begin
      if (strap_wait == `EPRGC_STRAP_WAIT) begin
        strap_taken <= 1'b1;
        bootloader_mode <= test_level_voltage_level & boot_level;
      end else begin
        strap_wait <= strap_wait + `EPRGC_STRAP_STEP;
      end
    end
  end

  // ========================================
  // Bus access
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i;
  wire rd = req & ~wb_we_i;
  wire hit_ctrl = (wb_adr_i == `EPRGC_REG_CTRL);
  wire hit_opt = (wb_adr_i == `EPRGC_REG_OPTION);
  wire hit_stat = (wb_adr_i == `EPRGC_REG_STATUS);
  wire hit_arr = in_array(wb_adr_i);
  wire locked = option_config_byte[`EPRGC_BIT_LOCK] & ~user_level;

  // One wait state; ack drops the cycle after it is given
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // ========================================
  // Control register
  reg next_latch;
  reg next_arr_pwr;
  always @* begin
    next_latch = prog_bus_latch;
    next_arr_pwr = array_prog_power;
    if (wr && hit_ctrl) begin
      next_latch = wb_dat_i[`EPRGC_BIT_LATCH];
      // Power only if latch was set before this write
      next_arr_pwr = wb_dat_i[`EPRGC_BIT_ARR_PWR] & prog_bus_latch;
      if (!next_latch) begin
        next_arr_pwr = 1'b0;
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prog_bus_latch <= 1'b0;
      array_prog_power <= 1'b0;
      option_prog_power <= 1'b0;
    end else begin
      prog_bus_latch <= next_latch;
      array_prog_power <= next_arr_pwr;
      if (wr && hit_ctrl) begin
        option_prog_power <= wb_dat_i[`EPRGC_BIT_OPT_PWR];
      end
    end
  end

  // ========================================
  // Array capture while latched
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prog_addr <= 16'h0000;
      prog_data <= `EPRGC_ZERO8;
      prog_captured <= 1'b0;
    end else begin
      if (!prog_bus_latch) begin
        prog_captured <= 1'b0;
      end else if (wr && hit_arr && !prog_captured && !locked) begin
        prog_addr <= wb_adr_i;
        prog_data <= wb_dat_i;
        prog_captured <= 1'b1;
      end
    end
  end

  // ========================================
  // Option byte
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      option_config_byte <= `EPRGC_ERASED8;
      option_written <= 1'b0;
      ext_osc_select <= 1'b1;
    end else begin
      option_written <= wr & hit_opt;
      if (wr && hit_opt) begin
        // Lock bit kept here; option reads hide it, status shows it only outside user mode
        option_config_byte <= wb_dat_i;
      end
      ext_osc_select <= option_config_byte[`EPRGC_BIT_OSC_SEL];
    end
  end

  // ========================================
  // Programming time monitors, array then option power
  wire [1:0] pwr_on = {option_prog_power, array_prog_power};
  wire [1:0] time_met;

  // Count restarts when power drops, so a short pulse never reads as met
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_timer
      reg [`EPRGC_CNT_W-1:0] count;
      wire [`EPRGC_CNT_W-1:0] limit = prog_limit(gi, bootloader_mode);
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          count <= {`EPRGC_CNT_W{1'b0}};
        end else if (!pwr_on[gi]) begin
          count <= {`EPRGC_CNT_W{1'b0}};
        end else if (count != limit) begin
          count <= count + 1'b1;
        end
      end
      assign time_met[gi] = (count == limit);
    end
  endgenerate

  // ========================================
  // Bootloader phase: copy pass, then verify pass
  localparam [2:0] boot_off = 3'b001;
  localparam [2:0] boot_copy = 3'b010;
  localparam [2:0] boot_verify = 3'b100;
  reg [2:0] boot_state;
  reg [2:0] next_boot_state;
  reg copied;

  always @* begin
    next_boot_state = boot_state;
    case (boot_state)
      boot_off: begin
        if (bootloader_mode) begin
          next_boot_state = boot_copy;
        end
      end
      boot_copy: begin
        // First plain array read after a copy starts verifying
        if (rd && hit_arr && !prog_bus_latch && copied) begin
          next_boot_state = boot_verify;
        end
      end
      boot_verify: begin
        // Verify pass lasts until the next reset
        next_boot_state = boot_verify;
      end
      default: begin
        next_boot_state = boot_off;
      end
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      boot_state <= boot_off;
      copied <= 1'b0;
    end else begin
      boot_state <= next_boot_state;
      copied <= copied | (bootloader_mode & prog_captured);
    end
  end

  // ========================================
  // Read data
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = `EPRGC_ZERO8;
    if (hit_ctrl) begin
      // Bits only seen while programming; otherwise all zero
      next_rdata = ctrl_view(prog_bus_latch, option_prog_power, array_prog_power);
    end else if (hit_opt) begin
      next_rdata[`EPRGC_BIT_OSC_SEL] = option_config_byte[`EPRGC_BIT_OSC_SEL];
    end else if (hit_stat) begin
      next_rdata = stat_view(bootloader_mode, locked, prog_captured, time_met, boot_state);
    end else if (hit_arr) begin
      if (prog_bus_latch || locked) begin
        next_rdata = `EPRGC_ERASED8;
      end else begin
        next_rdata = array_rd_data;
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= `EPRGC_ZERO8;
      bootloader_rom_sel <= 1'b0;
    end else begin
      if (rd) begin
        wb_dat_o <= next_rdata;
      end
      bootloader_rom_sel <= bootloader_mode & req & in_boot(wb_adr_i);
    end
  end

endmodule
`default_nettype wire

// ==== bench/eprgc_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module eprgc_assertions (
  input wire clock,
  input wire reset_n,
  input wire [15:0] wb_adr_i,
  input wire [7:0] wb_dat_i,
  input wire [7:0] wb_dat_o,
  input wire wb_we_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire array_prog_power,
  input wire option_prog_power,
  input wire prog_bus_latch,
  input wire [15:0] prog_addr,
  input wire prog_captured,
  input wire [7:0] option_config_byte,
  input wire ext_osc_select
);
  wire ct = wb_stb_i & ~wb_ack_o & (wb_adr_i == 16'h001E);
  wire ar = wb_stb_i & ~wb_ack_o & (wb_adr_i >= 16'h0600) & (wb_adr_i <= 16'h1DFF);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  pwr_latch_a: assert property ($rose(array_prog_power) |-> $past(prog_bus_latch)) else $error("pwr");
  latch_clr_a: assert property (!prog_bus_latch |-> !array_prog_power) else $error("clr");
  both_set_a: assert property (ct & wb_we_i & !prog_bus_latch |=> !array_prog_power) else $error("both");
  opt_pwr_a: assert property (ct & wb_we_i |=> option_prog_power == $past(wb_dat_i[1])) else $error("opt");
  osc_sel_a: assert property (ext_osc_select == $past(option_config_byte[0])) else $error("osc");
  ctrl_zero_a: assert property (ct & !wb_we_i |=> wb_dat_o[7:3] == 5'h00) else $error("ctrl");
  latch_rd_a: assert property (ar & !wb_we_i & prog_bus_latch |=> wb_dat_o == 8'hFF) else $error("rd");
  capture_a: assert property (ar & wb_we_i & prog_bus_latch & !prog_captured |=> prog_addr == $past(wb_adr_i))
    else $error("cap");
endmodule
`default_nettype wire

// ==== bench/eprgc_array_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module eprgc_array_model (
  input wire logic clock,
  input wire logic [15:0] wb_adr_i,
  input wire logic array_prog_power,
  input wire logic prog_captured,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] prog_data,
  output logic [7:0] array_rd_data
);
  logic [7:0] mem [0:8191] = '{default: 8'hFF};
  always @(posedge clock) begin
    if (array_prog_power && prog_captured) begin
      mem[prog_addr[12:0]] <= mem[prog_addr[12:0]] & prog_data;
    end
  end
  assign array_rd_data = mem[wb_adr_i[12:0]];
endmodule
`default_nettype wire

// ==== bench/test_eprom_program_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "eprgc_defs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; $display("unexpected %0t bad", $time); end end
module test_eprom_program_control;
  localparam logic [15:0] ctl = 16'h001E;
  localparam logic [15:0] arr = 16'h0600;
  logic clock = 0, reset_n = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_ack_o, user_mode = 1;
  logic test_level_voltage = 0, boot_select_pin = 0, prog_captured, ext_osc_select, bootloader_mode;
  logic array_prog_power, option_prog_power, prog_bus_latch;
  logic [15:0] wb_adr_i = 0, prog_addr;
  logic [7:0] wb_dat_i = 0, wb_dat_o, array_rd_data, prog_data, option_config_byte, q;
  int errors = 0, samples_checked = 0;
  always #12.5 clock = ~clock;
  eprgc_top i_eprgc_top (.wb_sel_i(1'b1), .option_written(), .bootloader_rom_sel(), .*);
  eprgc_array_model i_eprgc_array_model (.*);
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(0, a, 0);
    `CHK(q, e)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1;
    `CHK({option_config_byte, prog_bus_latch, option_prog_power, array_prog_power}, 11'h7F8)
    rd(ctl, 8'h00);
    rd(16'h0100, 8'h00);
    $display("reset test done");
    bus(1, ctl, 8'h05);
    rd(ctl, 8'h04);
    bus(1, arr, 8'hA5);
    `CHK({prog_captured, prog_addr}, 17'h10600)
    rd(arr, 8'hFF);
    bus(1, ctl, 8'h05);
    rd(ctl, 8'h05);
    repeat (`EPRGC_BYTE_PROG_CYC) @(posedge clock);
    rd(`EPRGC_REG_STATUS, 8'h0C);
    bus(1, ctl, 8'h01);
    rd(ctl, 8'h00);
    rd(arr, 8'hA5);
    rd(16'h1FF0, 8'hFF);
    $display("array test done");
    bus(1, 16'h002F, 8'h80);
    @(posedge clock);
    `CHK(ext_osc_select, 1'b0)
    bus(1, ctl, 8'h02);
    `CHK(option_prog_power, 1'b1)
    repeat (`EPRGC_BYTE_PROG_CYC) @(posedge clock);
    rd(`EPRGC_REG_STATUS, 8'h10);
    bus(1, ctl, 8'h00);
    user_mode <= 0;
    repeat (3) @(posedge clock);
    rd(arr, 8'hFF);
    $display("option test done");
    test_level_voltage <= 1;
    boot_select_pin <= 1;
    reset_n <= 0;
    repeat (4) @(posedge clock);
    reset_n <= 1;
    repeat (5) @(posedge clock);
    `CHK(bootloader_mode, 1'b1)
    rd(`EPRGC_REG_STATUS, 8'h23);
    user_mode <= 1;
    repeat (3) @(posedge clock);
    bus(1, ctl, 8'h04);
    bus(1, 16'h0601, 8'h3C);
    bus(1, ctl, 8'h00);
    rd(16'h0601, 8'hFF);
    rd(`EPRGC_REG_STATUS, 8'h41);
    $display("boot test done");
    wrap_up;
  end
endmodule
bind eprgc_top eprgc_assertions i_eprgc_assertions (.*);
`default_nettype wire
